// ### rtl/switch_event_interrupt_regs.sv
module switch_event_interrupt_regs #(
	parameter int ADDR_W = switch_event_pkg::ADDR_W,
	parameter int LINK_PORTS = switch_event_pkg::LINK_PORTS,
	parameter int FILTER_PORTS = switch_event_pkg::FILTER_PORTS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Write address channel
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// Write data channel
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// Write response channel
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address channel
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// Read data channel
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Switch events
	input wire logic [LINK_PORTS-1:0] link_up,
	input wire logic wake_event,
	input wire logic wake_ctrl_write,
	input wire logic [FILTER_PORTS-1:0] filter_event,
	// Host interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic do_write;
	logic do_read;
	logic low_lane;
	logic [ADDR_W-1:0] wr_word;
	logic [ADDR_W-1:0] rd_word;
	logic wr_hit_status;
	logic wr_hit_enable;
	logic wr_hit_filter_enable;
	logic wr_mapped;
	logic rd_hit_status;
	logic rd_hit_filter_status;
	logic [LINK_PORTS-1:0] link_changed;
	logic [4:0] event_set;
	logic [4:0] event_clr;
	logic [4:0] event_status;
	logic [4:0] filter_set;
	logic [4:0] filter_clr;
	logic [4:0] filter_event_flags;
	logic [4:0] event_enable;
	logic [4:0] filter_event_enables;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	localparam logic [31:0] DATA_ZERO_C = switch_event_pkg::DATA_ZERO;

	// ----------------------------------------------------------------
	// Write address and data capture, in either order
	// ----------------------------------------------------------------
	assign awready = !aw_held;
	assign wready = !w_held;
	assign do_write = aw_held && w_held && !bvalid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			wr_addr <= '0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			wr_addr <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			w_held <= 1'b0;
			wr_data <= DATA_ZERO_C;
			wr_strb <= 4'h0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			wr_data <= wdata;
			wr_strb <= wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wr_word = {wr_addr[ADDR_W-1:2], 2'h0};
	assign low_lane = wr_strb[0];

	always_comb begin
		wr_hit_status = 1'b0;
		wr_hit_enable = 1'b0;
		wr_hit_filter_enable = 1'b0;
		wr_mapped = 1'b1;
		if (wr_word == switch_event_pkg::ADDR_EVENT_STATUS) begin
			wr_hit_status = do_write && low_lane;
		end else if (wr_word == switch_event_pkg::ADDR_EVENT_ENABLE) begin
			wr_hit_enable = do_write && low_lane;
		end else if (wr_word == switch_event_pkg::ADDR_FILTER_ENABLE) begin
			wr_hit_filter_enable = do_write && low_lane;
		end else if (wr_word == switch_event_pkg::ADDR_FILTER_STATUS) begin
			wr_mapped = 1'b1;
		end else begin
			wr_mapped = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Write response
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bvalid <= 1'b0;
			bresp <= switch_event_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_mapped ? switch_event_pkg::RESP_OKAY : switch_event_pkg::RESP_DECERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	assign arready = !rvalid;
	assign do_read = arvalid && arready;
	assign rd_word = {araddr[ADDR_W-1:2], 2'h0};

	always_comb begin
		next_rdata = DATA_ZERO_C;
		next_rresp = switch_event_pkg::RESP_OKAY;
		rd_hit_status = 1'b0;
		rd_hit_filter_status = 1'b0;
		if (rd_word == switch_event_pkg::ADDR_EVENT_STATUS) begin
			next_rdata[4:0] = event_status & switch_event_pkg::EVENT_MASK;
			rd_hit_status = do_read;
		end else if (rd_word == switch_event_pkg::ADDR_EVENT_ENABLE) begin
			next_rdata[4:0] = event_enable & switch_event_pkg::EVENT_MASK;
		end else if (rd_word == switch_event_pkg::ADDR_FILTER_STATUS) begin
			next_rdata[4:0] = filter_event_flags;
			rd_hit_filter_status = do_read;
		end else if (rd_word == switch_event_pkg::ADDR_FILTER_ENABLE) begin
			next_rdata[4:0] = filter_event_enables;
		end else begin
			next_rresp = switch_event_pkg::RESP_DECERR;
		end
	end

	// ----------------------------------------------------------------
	// Read data channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			rdata <= DATA_ZERO_C;
			rresp <= switch_event_pkg::RESP_OKAY;
		end else if (do_read) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Link change detection
	// ----------------------------------------------------------------
	change_detect #(
		.WIDTH(LINK_PORTS)
	) u_link_change (
		.clk(clk),
		.rstn(rstn),
		.level(link_up),
		.changed(link_changed)
	);

	// ----------------------------------------------------------------
	// Event status sets and clears
	// ----------------------------------------------------------------
	always_comb begin
		event_set = switch_event_pkg::FLAGS_RESET;
		event_set[switch_event_pkg::PORT1_BIT] = link_changed[0];
		event_set[switch_event_pkg::PORT2_BIT] = link_changed[1];
		event_set[switch_event_pkg::PORT3_BIT] = link_changed[2];
		event_set[switch_event_pkg::WAKE_BIT] = wake_event;
	end

	always_comb begin
		event_clr = switch_event_pkg::FLAGS_RESET;
		if (wr_hit_status) begin
			event_clr = wr_data[4:0] & switch_event_pkg::EVENT_MASK;
		end
		if (rd_hit_status) begin
			event_clr = switch_event_pkg::EVENT_MASK;
		end
		if (wake_ctrl_write) begin
			event_clr[switch_event_pkg::WAKE_BIT] = 1'b1;
		end
	end

	sticky_flags #(
		.WIDTH(switch_event_pkg::FLAG_W)
	) u_event_status (
		.clk(clk),
		.rstn(rstn),
		.set(event_set),
		.clr(event_clr),
		.q(event_status)
	);

	// ----------------------------------------------------------------
	// Filter event flags
	// ----------------------------------------------------------------
	assign filter_set = 5'(filter_event);
	assign filter_clr = rd_hit_filter_status ? switch_event_pkg::FILTER_MASK : switch_event_pkg::FLAGS_RESET;

	sticky_flags #(
		.WIDTH(switch_event_pkg::FLAG_W)
	) u_filter_status (
		.clk(clk),
		.rstn(rstn),
		.set(filter_set),
		.clr(filter_clr),
		.q(filter_event_flags)
	);

	// ----------------------------------------------------------------
	// Enable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			event_enable <= switch_event_pkg::FLAGS_RESET;
		end else if (wr_hit_enable) begin
			event_enable <= wr_data[4:0] & switch_event_pkg::EVENT_MASK;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			filter_event_enables <= switch_event_pkg::FLAGS_RESET;
		end else if (wr_hit_filter_enable) begin
			filter_event_enables <= wr_data[4:0] & switch_event_pkg::FILTER_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Host interrupt
	// ----------------------------------------------------------------
	assign irq = (|(event_status & event_enable)) | (|(filter_event_flags & filter_event_enables));

endmodule // switch_event_interrupt_regs

// ### rtl/switch_event_pkg.sv
package switch_event_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'h7C;
	localparam logic [7:0] IDX_EVENT_ENABLE = 8'h7D;
	localparam logic [7:0] IDX_FILTER_STATUS = 8'h7E;
	localparam logic [7:0] IDX_FILTER_ENABLE = 8'h7F;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = {2'h0, IDX_EVENT_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_EVENT_ENABLE = {2'h0, IDX_EVENT_ENABLE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FILTER_STATUS = {2'h0, IDX_FILTER_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FILTER_ENABLE = {2'h0, IDX_FILTER_ENABLE, 2'h0};

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int FLAG_W = 5;
	localparam int PORT1_BIT = 0;
	localparam int PORT2_BIT = 1;
	localparam int PORT3_BIT = 2;
	localparam int WAKE_BIT = 4;
	localparam int LINK_PORTS = 3;
	localparam int FILTER_PORTS = 5;
	localparam logic [4:0] EVENT_MASK = 5'h17;
	localparam logic [4:0] FILTER_MASK = 5'h1F;
	localparam logic [4:0] FLAGS_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// ### rtl/sticky_flags.sv
module sticky_flags #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Set and clear requests
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clr,
	// Flags
	output logic [WIDTH-1:0] q
);

	// ----------------------------------------------------------------
	// Flags hold until cleared; a set in the clearing cycle wins.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= (q & ~clr) | set;
		end
	end

endmodule // sticky_flags

// ### rtl/change_detect.sv
module change_detect #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched levels
	input wire logic [WIDTH-1:0] level,
	// One-cycle pulse on each change
	output logic [WIDTH-1:0] changed
);

	logic [WIDTH-1:0] prev;
	logic primed;

	// ----------------------------------------------------------------
	// The first level after reset is taken as reference, not a change.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev <= '0;
			primed <= 1'b0;
		end else begin
			prev <= level;
			primed <= 1'b1;
		end
	end

	assign changed = primed ? (level ^ prev) : '0;

endmodule // change_detect

// ### dv/switch_event_monitor.sv
module switch_event_monitor #(
	parameter int LINK_PORTS = 3,
	parameter int FILTER_PORTS = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Events
	input wire logic [LINK_PORTS-1:0] link_up,
	input wire logic wake_event,
	input wire logic wake_ctrl_write,
	input wire logic [FILTER_PORTS-1:0] filter_event,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_read_next: assert property (arvalid && arready |=> rvalid)
		else $error("Read answer late.");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("Read data dropped.");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("Write answer dropped.");
	a_read_blocked: assert property (rvalid |-> !arready)
		else $error("Read taken while busy.");
	a_reserved_zero: assert property (rvalid |-> rdata[31:5] == 27'h0)
		else $error("Reserved bits set.");
	a_decerr_zero: assert property (rvalid && rresp == 2'h3 |-> rdata == 32'h0)
		else $error("Unmapped read not zero.");
	a_irq_fall: assert property ($fell(irq) |-> bvalid || $past(arvalid && arready || wake_ctrl_write))
		else $error("Interrupt fell without cause.");
	a_irq_rise: assert property ($rose(irq) |-> bvalid || $past(wake_event) || $past(|filter_event) ||
		$past(link_up, 1) != $past(link_up, 2))
		else $error("Interrupt rose without cause.");
	a_write_both: assert property ($rose(bvalid) |-> $past(!awready && !wready))
		else $error("Write answered early.");
endmodule // switch_event_monitor

// ### dv/host_model.sv
module host_model (
	// Clock
	input wire logic clk,
	// Write channels
	output logic awvalid,
	input wire logic awready,
	output logic [11:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	// Read channels
	output logic arvalid,
	input wire logic arready,
	output logic [11:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'hF;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		logic tb;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (ta) awaddr <= ~a;
			if (tw) wvalid <= 1'b0;
			if (tw) wdata <= ~d;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tr;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (ta) araddr <= ~a;
		end
		rready <= 1'b0;
	endtask
endmodule // host_model

// ### dv/test_switch_event_interrupt_regs.sv
module test_switch_event_interrupt_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] link_up = 3'h0;
	logic wake_event = 1'b0;
	logic wake_ctrl_write = 1'b0;
	logic [4:0] filter_event = 5'h00;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [11:0] adr [4] = '{switch_event_pkg::ADDR_EVENT_STATUS, switch_event_pkg::ADDR_EVENT_ENABLE,
		switch_event_pkg::ADDR_FILTER_STATUS, switch_event_pkg::ADDR_FILTER_ENABLE};
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	switch_event_interrupt_regs DUT (.clk, .rstn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
		.rdata, .rresp, .link_up, .wake_event, .wake_ctrl_write, .filter_event, .irq);
	host_model h (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
		.bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		h.rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic irqc(input logic e);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge clk);
	endtask
	task automatic ev(input logic w, input logic c, input logic [4:0] f);
		wake_event <= w;
		wake_ctrl_write <= c;
		filter_event <= f;
		@(posedge clk);
		{wake_event, wake_ctrl_write, filter_event} <= 7'h00;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 4; i++) rdc(adr[i], 32'h0, 2'h0);
		irqc(1'b0);
		$display("test reset done");
	endtask
	task automatic t_link();
		link_up[0] <= 1'b1;
		repeat (2) @(posedge clk);
		irqc(1'b0);
		rdc(adr[0], 32'h1, 2'h0);
		h.wr(adr[1], 32'h7, r);
		for (int i = 0; i < 3; i++) begin
			link_up[i] <= ~link_up[i];
			repeat (2) @(posedge clk);
			irqc(1'b1);
			rdc(adr[0], 32'h1 << i, 2'h0);
			irqc(1'b0);
			link_up[i] <= ~link_up[i];
			repeat (2) @(posedge clk);
			h.wr(adr[0], 32'h1 << i, r);
			irqc(1'b0);
		end
		$display("test link done");
	endtask
	task automatic t_wake();
		h.wr(adr[1], 32'h10, r);
		ev(1'b1, 1'b0, 5'h00);
		irqc(1'b1);
		rdc(adr[0], 32'h10, 2'h0);
		ev(1'b1, 1'b0, 5'h00);
		h.wr(adr[0], 32'h10, r);
		irqc(1'b0);
		ev(1'b1, 1'b0, 5'h00);
		irqc(1'b1);
		ev(1'b0, 1'b1, 5'h00);
		irqc(1'b0);
		$display("test wake done");
	endtask
	task automatic t_filter();
		h.wr(adr[1], 32'hFF, r);
		rdc(adr[1], 32'h17, 2'h0);
		h.wr(adr[3], 32'hFF, r);
		rdc(adr[3], 32'h1F, 2'h0);
		h.wr(adr[1], 32'h0, r);
		ev(1'b0, 1'b0, 5'h15);
		irqc(1'b1);
		h.wr(adr[2], 32'h1F, r);
		chk("bresp", 32'h0, {30'h0, r});
		irqc(1'b1);
		rdc(adr[2], 32'h15, 2'h0);
		irqc(1'b0);
		h.wr(adr[3], 32'h0A, r);
		ev(1'b0, 1'b0, 5'h15);
		irqc(1'b0);
		rdc(adr[2], 32'h15, 2'h0);
		rdc(12'h000, 32'h0, 2'h3);
		h.wr(12'h000, 32'h1, r);
		chk("bresp", 32'h3, {30'h0, r});
		$display("test filter done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_link();
		t_wake();
		t_filter();
		final_report();
	end
endmodule // test_switch_event_interrupt_regs

bind switch_event_interrupt_regs switch_event_monitor #(.LINK_PORTS(LINK_PORTS), .FILTER_PORTS(FILTER_PORTS)) mon (
	.clk, .rstn, .awready, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
	.rresp, .link_up, .wake_event, .wake_ctrl_write, .filter_event, .irq);
